// ==== core/indirect_access_mailbox_regs.v ====
/*
 * register slice: clock low threshold, two mailbox bytes, indirect
 * access window into port 0, port 1 and shared blocks, self-test control.
 * assumes a synchronous single-cycle register bus (wrEn/rdEn pulses)
 * and register blocks that answer combinationally at the given offset.
 */
`timescale 1ns/10ps
`include "mailbox_regs_defs.vh"

module indirect_access_mailbox_regs #(
	parameter THR_W = 4
) (
	// clock and reset
	input wire mclk,
	input wire rst_n,
	// register bus
	input wire [7:0] regAddr,
	input wire [7:0] regWdata,
	input wire regWrEn,
	input wire regRdEn,
	output reg [7:0] regRdata,
	// clock detector
	input wire [7:0] measuredFreqMhz,
	output wire noForwardClockFlag,
	// indirect target blocks
	output wire [7:0] indOffset,
	output wire [7:0] indWdata,
	output wire port0Wr,
	output wire port1Wr,
	output wire sharedWr,
	output wire port0Rd,
	output wire port1Rd,
	output wire sharedRd,
	input wire [7:0] port0Rdata,
	input wire [7:0] port1Rdata,
	input wire [7:0] sharedRdata,
	// self-test
	input wire [2:0] selfTestPinCfg,
	output wire [2:0] selfTestCfg,
	output wire selfTestEnable,
	output wire [1:0] selfTestOutputMode,
	input wire selfTestData,
	output reg selfTestToggle
);

	reg [THR_W-1:0] lowThreshold_reg;
	reg [7:0] mailboxA_reg;
	reg [7:0] mailboxB_reg;
	reg [3:0] targetSel_reg;
	reg autoInc_reg;
	reg readPrefetch_reg;
	reg [7:0] offset_reg;
	reg [7:0] data_reg;
	reg [7:0] selfTest_reg;
	reg wrStrobe_reg;
	reg rdStrobe_reg;
	reg [7:0] offset_next;
	reg [7:0] rdata_next;
	reg [7:0] liveData;

	// which blocks a target code reaches: {shared, port1, port0}
	// the pair code only counts for writes; reads under it reach nothing
	function [2:0] targetDecode;
		input [3:0] sel;
		input isWrite;
		begin
			case (sel)
				`SEL_PORT0: targetDecode = 3'h1;
				`SEL_PORT1: targetDecode = 3'h2;
				`SEL_SHARED: targetDecode = 3'h4;
				`SEL_BOTH_PORTS: targetDecode = isWrite ? 3'h3 : 3'h0;
				default: targetDecode = 3'h0;
			endcase
		end
	endfunction

	wire hitData = (regAddr == `OFS_IND_DATA);
	wire dataWr = regWrEn && hitData;
	wire dataRd = regRdEn && hitData;
	wire offsetWr = regWrEn && (regAddr == `OFS_IND_OFFSET);
	wire [2:0] wrTargets = targetDecode(targetSel_reg, 1'b1);
	wire [2:0] rdTargets = targetDecode(targetSel_reg, 1'b0);

	// strobes are registered one cycle after the bus access
	// a registered strobe keeps the bus decode off the block timing path;
	// the cost is that with auto-increment on, indOffset has already
	// moved when the write strobe arrives, so a block must latch the
	// offset seen in the access cycle to land the byte where the host
	// aimed it
	assign port0Wr = wrStrobe_reg && wrTargets[0];
	assign port1Wr = wrStrobe_reg && wrTargets[1];
	assign sharedWr = wrStrobe_reg && wrTargets[2];
	assign port0Rd = rdStrobe_reg && rdTargets[0];
	assign port1Rd = rdStrobe_reg && rdTargets[1];
	assign sharedRd = rdStrobe_reg && rdTargets[2];
	assign indOffset = offset_reg;
	assign indWdata = data_reg;

	// threshold compare in whole MHz
	// live compare, not sticky: the flag drops as soon as the clock returns
	assign noForwardClockFlag =
		(measuredFreqMhz < {{(8-THR_W){1'b0}}, lowThreshold_reg});

	// pin strap config wins while the pin-config bit is high
	assign selfTestCfg = selfTest_reg[`ST_PIN_BIT] ? selfTestPinCfg :
		selfTest_reg[2:0];
	assign selfTestEnable = selfTest_reg[`ST_ENABLE_BIT];
	assign selfTestOutputMode = selfTest_reg[`ST_MODE_MSB:`ST_MODE_LSB];

	// live read of selected block, never a stored copy
	// the pair code reaches two blocks at once, so there is no single
	// value to return and it reads zero, as do the reserved codes
	always @* begin
		case (targetSel_reg)
			`SEL_PORT0: liveData = port0Rdata;
			`SEL_PORT1: liveData = port1Rdata;
			`SEL_SHARED: liveData = sharedRdata;
			default: liveData = 8'h00;
		endcase
	end

	// readback mux; reserved and unmapped offsets read zero
	// the threshold byte keeps its upper bits at zero: hysteresis and
	// stability fields live outside this slice
	always @* begin
		case (regAddr)
			`OFS_FREQ_CTL: rdata_next = {{(8-THR_W){1'b0}}, lowThreshold_reg};
			`OFS_MAILBOX_A: rdata_next = mailboxA_reg;
			`OFS_MAILBOX_B: rdata_next = mailboxB_reg;
			`OFS_IND_CTL: rdata_next = {2'h0, targetSel_reg, autoInc_reg,
				readPrefetch_reg};
			`OFS_IND_OFFSET: rdata_next = offset_reg;
			`OFS_IND_DATA: rdata_next = liveData;
			`OFS_SELF_TEST: rdata_next = selfTest_reg;
			default: rdata_next = 8'h00;
		endcase
	end

	// with auto-increment on, offset bumps after a completed data access; host write wins
	// an offset write and a data access never meet in one cycle on a
	// single-access bus or any other, since both decode the one regAddr; the priority never takes effect
	always @* begin
		offset_next = offset_reg;
		if (offsetWr)
			offset_next = regWdata;
		else if (autoInc_reg && (dataWr || dataRd))
			offset_next = offset_reg + 8'h01;
	end

	// register file and strobes
	// writes to reserved or unmapped offsets fall through and are dropped
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			lowThreshold_reg <= `RST_LOW_THRESHOLD;
			mailboxA_reg <= `RST_MAILBOX_A;
			mailboxB_reg <= `RST_MAILBOX_B;
			targetSel_reg <= 4'h0;
			autoInc_reg <= 1'b0;
			readPrefetch_reg <= 1'b0;
			offset_reg <= 8'h00;
			data_reg <= 8'h00;
			selfTest_reg <= `RST_SELF_TEST;
			wrStrobe_reg <= 1'b0;
			rdStrobe_reg <= 1'b0;
			regRdata <= 8'h00;
		end else begin
			offset_reg <= offset_next;
			wrStrobe_reg <= dataWr;
			// the prefetch strobe reads at the already updated offset
			rdStrobe_reg <= readPrefetch_reg &&
				(offsetWr || (dataRd && autoInc_reg));
			if (regRdEn)
				regRdata <= rdata_next;
			if (regWrEn) begin
				case (regAddr)
					`OFS_FREQ_CTL: lowThreshold_reg <= regWdata[THR_W-1:0];
					`OFS_MAILBOX_A: mailboxA_reg <= regWdata;
					`OFS_MAILBOX_B: mailboxB_reg <= regWdata;
					`OFS_IND_CTL: begin
						targetSel_reg <= regWdata[`CTL_SEL_MSB:`CTL_SEL_LSB];
						autoInc_reg <= regWdata[`CTL_AUTOINC_BIT];
						readPrefetch_reg <= regWdata[`CTL_READ_BIT];
					end
					`OFS_IND_DATA: data_reg <= regWdata;
					`OFS_SELF_TEST: selfTest_reg <= regWdata;
					default: ;
				endcase
			end
		end
	end

	// output pattern: held low, alternating, or following data
	// clearing the enable bit parks the output low on the next clock edge, whatever the
	// mode, so a stopped test never leaves a stale level on the pin
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			selfTestToggle <= 1'b0;
		else if (!selfTest_reg[`ST_ENABLE_BIT])
			selfTestToggle <= 1'b0;
		else begin
			case (selfTest_reg[`ST_MODE_MSB:`ST_MODE_LSB])
				`MODE_NONE: selfTestToggle <= 1'b0;
				`MODE_ALT: selfTestToggle <= ~selfTestToggle;
				default: selfTestToggle <= selfTestData;
			endcase
		end
	end

endmodule

// ==== core/mailbox_regs_defs.vh ====
/*
 * offsets, field positions, reset values and target codes of the
 * indirect window and mailbox register slice.
 * assumes an 8-bit offset register bus inside the device.
 */
`ifndef MAILBOX_REGS_DEFS_VH
`define MAILBOX_REGS_DEFS_VH

`define OFS_FREQ_CTL 8'h77
`define OFS_MAILBOX_A 8'h78
`define OFS_MAILBOX_B 8'h79
`define OFS_RSVD_LO 8'h7A
`define OFS_RSVD_HI 8'h7F
`define OFS_IND_CTL 8'hB0
`define OFS_IND_OFFSET 8'hB1
`define OFS_IND_DATA 8'hB2
`define OFS_SELF_TEST 8'hB3

`define RST_LOW_THRESHOLD 4'h5
`define RST_MAILBOX_A 8'h00
`define RST_MAILBOX_B 8'h01
`define RST_SELF_TEST 8'h08

`define CTL_READ_BIT 0
`define CTL_AUTOINC_BIT 1
`define CTL_SEL_LSB 2
`define CTL_SEL_MSB 5
`define ST_ENABLE_BIT 0
`define ST_PIN_BIT 3
`define ST_MODE_LSB 6
`define ST_MODE_MSB 7

`define SEL_PORT0 4'h1
`define SEL_PORT1 4'h2
`define SEL_SHARED 4'h5
`define SEL_BOTH_PORTS 4'h6

`define MODE_NONE 2'h0
`define MODE_ALT 2'h1

`endif

// ==== tb/iamr_checker.sv ====
/* checker: port timing of the indirect window slice.
   assumes it is bound onto the design top. */
`timescale 1ns/10ps
module iamr_checker(
	input wire mclk, rst_n, regWrEn, regRdEn, port0Wr, port1Wr, sharedWr,
	input wire port0Rd, port1Rd, sharedRd, noForwardClockFlag,
	input wire selfTestEnable, selfTestToggle,
	input wire [1:0] selfTestOutputMode,
	input wire [7:0] regAddr, regWdata, measuredFreqMhz, indOffset, indWdata
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	wire anyWr = port0Wr | port1Wr | sharedWr;
	wire anyRd = port0Rd | port1Rd | sharedRd;
	// four-bit threshold, so 16 MHz or more is never a lost clock
	flag_range_a: assert property (measuredFreqMhz > 8'h0F |->
		!noForwardClockFlag) else $error("flag set above range");
	offset_load_a: assert property (regWrEn && regAddr == 8'hB1 |=>
		indOffset == $past(regWdata)) else $error("offset not loaded");
	data_load_a: assert property (regWrEn && regAddr == 8'hB2 |=>
		indWdata == $past(regWdata)) else $error("data not loaded");
	wr_cause_a: assert property (anyWr |-> $past(regWrEn) &&
		$past(regAddr) == 8'hB2) else $error("stray write strobe");
	rd_cause_a: assert property (anyRd |-> $past(regWrEn &&
		regAddr == 8'hB1 || regRdEn && regAddr == 8'hB2))
		else $error("stray read strobe");
	one_target_a: assert property ($onehot0({port0Rd, port1Rd, sharedRd}))
		else $error("two read targets");
	pair_write_a: assert property (port0Wr && port1Wr |-> !sharedWr)
		else $error("shared hit by pair write");
	quiet_toggle_a: assert property (!selfTestEnable ||
		selfTestOutputMode == 2'h0 |=> !selfTestToggle)
		else $error("toggle while quiet");
	cover property (port0Wr && port1Wr);
	cover property (anyRd && $past(regRdEn));
	cover property (selfTestToggle);
endmodule
bind indirect_access_mailbox_regs iamr_checker iamr_checker_i(.mclk,
	.rst_n, .regWrEn, .regRdEn, .port0Wr, .port1Wr, .sharedWr, .port0Rd,
	.port1Rd, .sharedRd, .noForwardClockFlag, .selfTestEnable,
	.selfTestToggle, .selfTestOutputMode, .regAddr, .regWdata,
	.measuredFreqMhz, .indOffset, .indWdata);

// ==== tb/target_blocks.sv ====
/* model of port 0, port 1 and shared register blocks.
   assumes strobes come one cycle after the bus access. */
`timescale 1ns/10ps
module target_blocks(
	input wire mclk,
	input wire [7:0] indOffset, indWdata,
	input wire port0Wr, port1Wr, sharedWr, port0Rd, port1Rd, sharedRd,
	output wire [7:0] port0Rdata, port1Rdata, sharedRdata
);
	reg [7:0] mem [0:2][0:255];
	reg [7:0] lastOff;
	integer rdCount = 0, b, i;
	// distinct pattern per block so a wrong target shows
	initial begin
		for (b = 0; b < 3; b++)
			for (i = 0; i < 256; i++)
				mem[b][i] = i ^ (b * 64);
	end
	// strobe lands after auto-increment, so use last cycle's offset
	always @(posedge mclk) begin
		lastOff <= indOffset;
		for (b = 0; b < 3; b++)
			if ({sharedWr, port1Wr, port0Wr} >> b & 1)
				mem[b][lastOff] <= indWdata;
		if (port0Rd | port1Rd | sharedRd)
			rdCount <= rdCount + 1;
	end
	// live contents, no stored copy
	assign port0Rdata = mem[0][indOffset];
	assign port1Rdata = mem[1][indOffset];
	assign sharedRdata = mem[2][indOffset];
endmodule

// ==== tb/indirect_access_mailbox_regs_bench.sv ====
/* bench for the indirect window slice.
   assumes the target block model answers the window. */
`timescale 1ns/10ps
module indirect_access_mailbox_regs_bench;
	reg mclk = 0, rst_n = 0, regWrEn = 0, regRdEn = 0, selfTestData = 0, t;
	reg [7:0] regAddr = 8'h00, regWdata = 8'h00, measuredFreqMhz = 8'h00;
	reg [2:0] selfTestPinCfg = 3'h5;
	wire [7:0] regRdata, indOffset, indWdata;
	wire [7:0] port0Rdata, port1Rdata, sharedRdata;
	wire [2:0] selfTestCfg;
	wire [1:0] selfTestOutputMode;
	wire noForwardClockFlag, selfTestEnable, selfTestToggle;
	wire port0Wr, port1Wr, sharedWr, port0Rd, port1Rd, sharedRd;
	integer n_errors = 0, comparisons = 0, cyc = 0, s, k;
	indirect_access_mailbox_regs indirect_access_mailbox_regs_i(.mclk,
		.rst_n, .regAddr, .regWdata, .regWrEn, .regRdEn, .regRdata,
		.measuredFreqMhz, .noForwardClockFlag, .indOffset, .indWdata,
		.port0Wr, .port1Wr, .sharedWr, .port0Rd, .port1Rd, .sharedRd,
		.port0Rdata, .port1Rdata, .sharedRdata, .selfTestPinCfg,
		.selfTestCfg, .selfTestEnable, .selfTestOutputMode,
		.selfTestData, .selfTestToggle);
	target_blocks target_blocks_i(.mclk, .indOffset, .indWdata, .port0Wr,
		.port1Wr, .sharedWr, .port0Rd, .port1Rd, .sharedRd, .port0Rdata,
		.port1Rdata, .sharedRdata);
	initial forever #20 mclk = ~mclk;
	task chk(input [7:0] g, e);
		comparisons++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %0t got %h want %h", $time, g, e);
		end
	endtask
	task wr8(input [7:0] a, d);
		@(posedge mclk);
		regAddr <= a;
		regWdata <= d;
		regWrEn <= 1'b1;
		@(posedge mclk);
		regWrEn <= 1'b0;
	endtask
	// read data is settled just after the edge that follows the pulse
	task rd8(input [7:0] a, e);
		@(posedge mclk);
		regAddr <= a;
		regRdEn <= 1'b1;
		@(posedge mclk);
		regRdEn <= 1'b0;
		#1 chk(regRdata, e);
	endtask
	task report_and_stop;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// a hung handshake cannot stall the run past this
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 2000) begin
			n_errors++;
			report_and_stop;
		end
	end
	initial begin
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
		rd8(8'h77, 8'h05);
		rd8(8'h79, 8'h01);
		rd8(8'hB3, 8'h08);
		chk(selfTestCfg, 8'h05);
		wr8(8'h78, 8'hA5);
		rd8(8'h78, 8'hA5);
		wr8(8'h7A, 8'hFF);
		rd8(8'h7A, 8'h00);
		wr8(8'h77, 8'h03);
		measuredFreqMhz <= 8'h02;
		@(posedge mclk);
		#1 chk(noForwardClockFlag, 8'h01);
		measuredFreqMhz <= 8'h03;
		@(posedge mclk);
		#1 chk(noForwardClockFlag, 8'h00);
		// each single target with auto-increment; control, offset, data
		for (s = 0; s < 3; s++) begin
			wr8(8'hB0, 8'(s == 2 ? 8'h16 : s * 4 + 6));
			wr8(8'hB1, 8'h10);
			wr8(8'hB2, 8'(8'hC0 + s));
			@(posedge mclk);
			#1 chk(target_blocks_i.mem[s][16], 8'(8'hC0 + s));
			rd8(8'hB2, 8'(8'h11 ^ s * 64));
			chk(indOffset, 8'h12);
		end
		wr8(8'hB0, 8'h1A);
		wr8(8'hB1, 8'h20);
		wr8(8'hB2, 8'h77);
		@(posedge mclk);
		#1 chk(target_blocks_i.mem[0][32], 8'h77);
		chk(target_blocks_i.mem[1][32], 8'h77);
		chk(target_blocks_i.mem[2][32], 8'hA0);
		rd8(8'hB2, 8'h00);
		wr8(8'hB0, 8'h07);
		rd8(8'hB0, 8'h07);
		k = target_blocks_i.rdCount;
		wr8(8'hB1, 8'h30);
		@(posedge mclk);
		#1 chk(8'(target_blocks_i.rdCount), 8'(k + 1));
		rd8(8'hB2, 8'h30);
		@(posedge mclk);
		#1 chk(8'(target_blocks_i.rdCount), 8'(k + 2));
		wr8(8'hB3, 8'h41);
		repeat (2) @(posedge mclk);
		#1 chk(selfTestEnable, 8'h01);
		chk(selfTestCfg, 8'h01);
		chk(selfTestOutputMode, 8'h01);
		t = selfTestToggle;
		@(posedge mclk);
		#1 chk(selfTestToggle, !t);
		selfTestData <= 1'b1;
		wr8(8'hB3, 8'h81);
		repeat (2) @(posedge mclk);
		#1 chk(selfTestToggle, 8'h01);
		wr8(8'hB3, 8'h80);
		repeat (2) @(posedge mclk);
		#1 chk(selfTestToggle, 8'h00);
		report_and_stop;
	end
endmodule
